/* core/brp_pkg.sv */
// Package for the request-driven BCD result port: timing constants and widths.
// Assumes a 20 MHz core clock.
package brp_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned DIGITS = 5;
  localparam int unsigned DATA_W = 4 * DIGITS;
  // Times in milliseconds
  localparam int unsigned T_SAMPLE_MS = 30;
  localparam int unsigned T_VALID_MS = 40;
  localparam int unsigned T_RELEASE_MS = 16;
  localparam int unsigned T_REPEAT_MS = 64;
  localparam int unsigned T_SPACING_MS = 20;
  // Cycle counts derived from the rate
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned C_SAMPLE = T_SAMPLE_MS * CYC_PER_MS;
  localparam int unsigned C_VALID = T_VALID_MS * CYC_PER_MS;
  localparam int unsigned C_RELEASE = T_RELEASE_MS * CYC_PER_MS;
  localparam int unsigned C_REPEAT = T_REPEAT_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 21;
  localparam logic [DATA_W-1:0] DATA_RST = 20'h00000;
  typedef enum logic [2:0] {BRP_IDLE, BRP_WAIT, BRP_VALID, BRP_HOLD, BRP_GAP} brp_state_t;
endpackage

/* core/brp_port.sv */
// Request-driven parallel BCD result port: samples on request, strobes valid,
// releases data, repeats while request is held. Assumes i_meas is a coherent
// BCD word from logic on i_clk; i_req and i_freeze come from pins.
// MS_CYCLES sets the timebase; its default gives the real millisecond spans.
// Functional notes
// - No BCD data is driven unless the outside requester has raised the request.
// - About 30 ms after the request rises a sample is taken and valid is asserted.
// - In single sampling valid drops after 40 ms and the data release 16 ms later.
// - While request stays high a new measurement is presented every 64 ms.
// - Freeze during a word change holds one whole word, never a mixture.
`timescale 1ns/1ps
module brp_port
  import brp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = brp_pkg::CYC_PER_MS // Clock cycles per millisecond
)
(
  input wire logic i_clk, // 20 MHz clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_req, // Measurement request pin
  input wire logic i_freeze, // Freeze (hold) pin
  input wire logic [brp_pkg::DATA_W-1:0] i_meas, // Current measured BCD value
  output logic [brp_pkg::DATA_W-1:0] o_bcd, // BCD digits
  output logic o_bcd_en, // High while digits are driven
  output logic o_valid // Result valid strobe
);
  import brp_pkg::*;

  // Cycle counts follow the timebase, so a bench may run a faster one
  localparam int unsigned SAMPLE_CYC = T_SAMPLE_MS * MS_CYCLES;
  localparam int unsigned VALID_CYC = T_VALID_MS * MS_CYCLES;
  localparam int unsigned RELEASE_CYC = T_RELEASE_MS * MS_CYCLES;
  localparam int unsigned REPEAT_CYC = T_REPEAT_MS * MS_CYCLES;
  localparam int unsigned GAP_CYC = REPEAT_CYC - VALID_CYC;
  localparam int unsigned N_PINS = 2;

  logic [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_sync;
  logic req_sync;
  logic frz_sync;

  logic req_dly_q;
  logic req_dly_d;
  logic req_rise;

  brp_state_t state_q;
  brp_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic en_q;
  logic en_d;
  logic valid_q;
  logic valid_d;
  logic load;

  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] bcd_q;
  logic [DATA_W-1:0] bcd_d;

  assign pin_raw = {i_freeze, i_req};

  // Both pins are asynchronous: two flops each before any logic reads them
  for (genvar p = 0; p < N_PINS; p++) begin : g_sync
    logic s1_q;
    logic s1_d;
    logic s2_q;
    logic s2_d;
    always_comb begin
      s1_d = pin_raw[p];
      s2_d = s1_q;
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= s1_d;
        s2_q <= s2_d;
      end
    end
    assign pin_sync[p] = s2_q;
  end

  assign req_sync = pin_sync[0];
  assign frz_sync = pin_sync[1];

  // Edge stage rests low like the idle pin, so no false edge after reset
  always_comb begin
    req_dly_d = req_sync;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      req_dly_q <= 1'b0;
    end else begin
      req_dly_q <= req_dly_d;
    end
  end

  assign req_rise = req_sync && !req_dly_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    en_d = en_q;
    valid_d = valid_q;
    load = 1'b0;
    unique case (state_q)
      BRP_IDLE: begin
        // Edges are only taken here; a cycle in progress is never restarted
        if (req_rise) begin
          state_d = BRP_WAIT;
          cnt_d = CNT_W'(SAMPLE_CYC - 1);
        end
      end
      BRP_WAIT: begin
        if (cnt_q == '0) begin
          load = !frz_sync; // Frozen: keep last whole word
          en_d = 1'b1;
          valid_d = 1'b1;
          state_d = BRP_VALID;
          cnt_d = CNT_W'(VALID_CYC - 1);
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      BRP_VALID: begin
        // Request level at the strobe end picks repeat or release
        if (cnt_q == '0) begin
          valid_d = 1'b0;
          if (req_sync) begin
            state_d = BRP_GAP;
            cnt_d = CNT_W'(GAP_CYC - 1);
          end else begin
            state_d = BRP_HOLD;
            cnt_d = CNT_W'(RELEASE_CYC - 1);
          end
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      BRP_HOLD: begin
        if (cnt_q == '0) begin
          en_d = 1'b0;
          state_d = BRP_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      BRP_GAP: begin
        // Strobe low here, so the word may change safely
        if (!req_sync) begin
          state_d = BRP_HOLD;
          cnt_d = CNT_W'(RELEASE_CYC - 1);
        end else if (cnt_q == '0) begin
          load = !frz_sync;
          valid_d = 1'b1;
          state_d = BRP_VALID;
          cnt_d = CNT_W'(VALID_CYC - 1);
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        // Unused state codes fall back to a quiet idle
        state_d = BRP_IDLE;
        cnt_d = '0;
        en_d = 1'b0;
        valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= BRP_IDLE;
      cnt_q <= '0;
      en_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      en_q <= en_d;
      valid_q <= valid_d;
    end
  end

  // Word loads with valid rising, so it is steady through the strobe
  brp_word_reg u_word (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_load(load),
    .i_data(i_meas),
    .o_data(word)
  );

  // Digit lines leave a flop; off state reads as zero
  // Mirrors the word register so lines and enable move on the same edge
  always_comb begin
    if (!en_d) begin
      bcd_d = DATA_RST;
    end else if (load) begin
      bcd_d = i_meas;
    end else begin
      bcd_d = word;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bcd_q <= DATA_RST;
    end else begin
      bcd_q <= bcd_d;
    end
  end

  assign o_bcd = bcd_q;
  assign o_bcd_en = en_q;
  assign o_valid = valid_q;
endmodule

/* core/brp_word_reg.sv */
// Word register that loads only on a load strobe, so its output is never a mix.
// Assumes load and data are on the same clock.
`timescale 1ns/1ps
module brp_word_reg
  import brp_pkg::*;
(
  input wire logic i_clk, // Core clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_load, // Load strobe
  input wire logic [brp_pkg::DATA_W-1:0] i_data, // Word to load
  output logic [brp_pkg::DATA_W-1:0] o_data // Registered word
);
  logic [DATA_W-1:0] word_q;
  logic [DATA_W-1:0] word_d;
  always_comb begin
    word_d = i_load ? i_data : word_q;
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      word_q <= DATA_RST;
    end else begin
      word_q <= word_d;
    end
  end
  assign o_data = word_q;
endmodule

/* verification/brp_plc.sv */
// Controller model: requests on command, latches digits.
// Assumes the port pins on one clock.
`timescale 1ns/1ps
module brp_plc
(
  input wire logic i_clk, // Clock
  input wire logic i_go, // Command
  input wire logic i_valid, // Strobe
  input wire logic [brp_pkg::DATA_W-1:0] i_bcd, // Digits
  output logic o_req, // Request
  output logic [brp_pkg::DATA_W-1:0] o_word // Latched
);
  assign o_req = i_go;
  always_ff @(posedge i_clk) if (i_valid) o_word <= i_bcd;
endmodule

/* verification/brp_port_assertions.sv */
// Checker on the result port pins.
// Assumes one clock; bound into every port.
`timescale 1ns/1ps
module brp_port_chk
  import brp_pkg::*;
#(
  parameter int unsigned MS_CYCLES = brp_pkg::CYC_PER_MS // Cycles per millisecond
)
(
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Reset
  input wire logic i_req, // Request
  input wire logic i_freeze, // Freeze
  input wire logic [brp_pkg::DATA_W-1:0] o_bcd, // Digits
  input wire logic o_bcd_en, // Driven
  input wire logic o_valid // Strobe
);
  localparam int unsigned SAMPLE_CYC = T_SAMPLE_MS * MS_CYCLES;
  localparam int unsigned VALID_CYC = T_VALID_MS * MS_CYCLES;
  localparam int unsigned RELEASE_CYC = T_RELEASE_MS * MS_CYCLES;
  localparam int unsigned REPEAT_CYC = T_REPEAT_MS * MS_CYCLES;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic seen_q;
  int unsigned v_q;
  int unsigned l_q;
  int unsigned p_q;
  int unsigned r_q;
  // Counters stand in for long repetitions
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      seen_q <= 1'b0;
      v_q <= 0;
      l_q <= 0;
      p_q <= 0;
      r_q <= 0;
    end else begin
      seen_q <= i_req | (seen_q & !$fell(o_bcd_en));
      v_q <= o_valid ? v_q + 1 : 0;
      l_q <= (o_bcd_en & !o_valid) ? l_q + 1 : 0;
      p_q <= $rose(o_valid) ? 1 : p_q + 1;
      r_q <= $rose(i_req) ? 1 : r_q + 1;
    end
  end
  sequence s_reload;
    $rose(o_valid) && $past(o_bcd_en);
  endsequence
  a_req_first: assert property ($rose(o_bcd_en) |-> seen_q) else $error("no request");
  a_sample_delay: assert property ($rose(o_valid) && !$past(o_bcd_en) |->
    r_q inside {[SAMPLE_CYC+1:SAMPLE_CYC+6]}) else $error("sample delay");
  a_valid_width: assert property ($fell(o_valid) |-> v_q == VALID_CYC)
    else $error("width");
  a_release_gap: assert property ($fell(o_bcd_en) |-> l_q == RELEASE_CYC)
    else $error("off");
  a_repeat_period: assert property (s_reload |-> p_q == REPEAT_CYC)
    else $error("period");
  a_word_stable: assert property (o_valid && $past(o_valid) |-> $stable(o_bcd))
    else $error("digits moved");
  a_freeze_hold: assert property (i_freeze[*4] ##0 s_reload |-> $stable(o_bcd))
    else $error("freeze lost");
endmodule
bind brp_port brp_port_chk #(.MS_CYCLES(MS_CYCLES)) brp_port_chk_inst (.i_clk, .i_resetn,
  .i_req, .i_freeze, .o_bcd, .o_bcd_en, .o_valid);

/* verification/brp_port_tb_top.sv */
// Bench: single and continuous reads, freeze.
// Assumes the checker bind and controller model.
`timescale 1ns/1ps
module brp_port_tb_top;
  import brp_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, go = 1'b0, i_freeze = 1'b0, o_req, o_bcd_en, o_valid;
  logic [DATA_W-1:0] i_meas = 20'h12345, o_bcd, word;
  int failures = 0, cmp_count = 0, n;
  // Fast timebase: 20 cycles stand for 1 ms, so the run stays short
  localparam int unsigned MS = 20;
  localparam int unsigned LIMIT = 4 * T_REPEAT_MS * MS;
  localparam int unsigned WDOG = 4 * (T_SAMPLE_MS + T_VALID_MS + T_RELEASE_MS + T_REPEAT_MS +
    T_SPACING_MS) * MS;
  always #25 i_clk = ~i_clk;
  brp_port #(.MS_CYCLES(MS)) brp_port_inst (.i_clk, .i_resetn, .i_req(o_req), .i_freeze,
    .i_meas, .o_bcd, .o_bcd_en, .o_valid);
  brp_plc brp_plc_inst (.i_clk, .i_go(go), .i_valid(o_valid), .i_bcd(o_bcd), .o_req,
    .o_word(word));
  task chk(input logic [31:0] a, e);
    cmp_count++;
    if (a !== e) begin
      $display("BAD %0t %h %h", $time, a, e);
      failures++;
    end
  endtask
  task wt(input bit s, input logic v);
    for (n = 0; (s ? o_bcd_en : o_valid) !== v && n < LIMIT; n++) @(negedge i_clk);
    if (n >= LIMIT) begin
      $display("BAD %0t %h %h", $time, n, LIMIT);
      failures++;
    end
  endtask
  task stop_test;
    $display("cmp %0d bad %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_single;
    chk(o_bcd_en, 1'b0);
    go = 1'b1;
    repeat (10) @(negedge i_clk);
    go = 1'b0;
    wt(0, 1'b1);
    chk(o_bcd, 20'h12345);
    wt(0, 1'b0);
    chk(n, T_VALID_MS * MS);
    chk(word, 20'h12345);
    wt(1, 1'b0);
    chk(n, T_RELEASE_MS * MS);
    chk(o_bcd, DATA_RST);
    repeat (T_SPACING_MS * MS) @(negedge i_clk);
  endtask
  task t_cont;
    i_meas = 20'h24680;
    go = 1'b1;
    wt(0, 1'b1);
    i_meas = 20'h13579;
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk(n, (T_REPEAT_MS - T_VALID_MS) * MS);
    chk(o_bcd, 20'h13579);
    i_freeze = 1'b1;
    i_meas = 20'h97531;
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk(o_bcd, 20'h13579);
    go = 1'b0;
    wt(1, 1'b0);
    chk(n, (T_VALID_MS + T_RELEASE_MS) * MS);
  endtask
  initial begin
    repeat (8) @(negedge i_clk);
    i_resetn = 1'b1;
    t_single;
    t_cont;
    stop_test;
  end
  initial begin
    repeat (WDOG) @(posedge i_clk);
    failures++;
    stop_test;
  end
endmodule
